// *** rtl/rcsr_defs.svh ***
// Constants of the reset-cause register and of the internal reset sequencer.
// Assumes a single system clock; included by its bare name.
`ifndef RCSR_DEFS_SVH
`define RCSR_DEFS_SVH

`define RCSR_SFR_ADDR      8'hEF
`define RCSR_BIT_PIN       0
`define RCSR_BIT_POR       1
`define RCSR_BIT_LOSS      2
`define RCSR_BIT_WDT       3
`define RCSR_BIT_SW        4
`define RCSR_BIT_CMP       5
`define RCSR_BIT_FLASH     6
`define RCSR_BIT7_VALUE    1'b1
`define RCSR_FLAGS_POR     7'h02
`define RCSR_EN_RESET      3'h1
`define RCSR_SYNC_INIT     4'h3
`define RCSR_RDATA_IDLE    8'h00
`define RCSR_HOLD_CYCLES   16

`endif

// *** rtl/rcsr_pkg.sv ***
// Types shared by the reset-cause register block.
// Assumes the constants header is available on the include path.
package rcsr_pkg;

  // Cause flags in register order, bit 6 down to bit 0.
  typedef struct packed {
    logic flash_fault_flag;
    logic comparator_reset_flag;
    logic soft_reset_flag;
    logic watchdog_flag;
    logic clock_loss_flag;
    logic power_on_flag;
    logic pin_reset_flag;
  } rcsr_flags_t;

  // Written enables that survive every system reset.
  typedef struct packed {
    logic cmp_en;
    logic loss_en;
    logic vdd_en;
  } rcsr_en_t;

  // Special-function register access from the core.
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } rcsr_sfr_req_t;

  typedef enum logic [0:0] {
    ST_RUN,
    ST_HOLD
  } rcsr_state_t;

endpackage

// *** rtl/rcsr_top.sv ***
// Reset-cause register and internal system reset sequencer.
// Assumes rst_n is the power-on reset, detectors sit outside, and the core
// reaches the register through a simple special-function register port.
`timescale 1ns/1ps
`include "rcsr_defs.svh"

module rcsr_top #(
  parameter int HOLD_CYCLES = `RCSR_HOLD_CYCLES
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic                   rst_pin_n,
  input  wire logic                   cmp_out_n,
  input  wire logic                   clk_loss_timeout,
  input  wire logic                   vdd_low,
  input  wire logic                   wdt_timeout,
  input  wire logic                   flash_fault,
  input  wire rcsr_pkg::rcsr_sfr_req_t sfr,
  output logic [7:0]                  sfr_rdata,
  output logic                        sys_rst_n,
  output logic                        clock_loss_en,
  output logic                        comparator_rst_en,
  output logic                        vdd_rst_en
);
  import rcsr_pkg::*;

  // The down counter is eight bits wide and must reach zero at least once.
  initial begin
    if (HOLD_CYCLES < 2 || HOLD_CYCLES > 256) begin
      $error("HOLD_CYCLES must lie between 2 and 256");
    end
  end

  localparam logic [7:0] HOLD_LOAD = 8'(HOLD_CYCLES - 1);

  logic [3:0]  sync1_q;
  logic [3:0]  sync2_q;
  rcsr_state_t state_q, state_d;
  logic [7:0]  cnt_q, cnt_d;
  rcsr_flags_t flags_q, flags_d;
  rcsr_en_t    en_q, en_d;
  logic        rst_q, rst_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        pin_low;
  logic        cmp_trip;
  logic        loss_trip;
  logic        vdd_trip;
  logic        hit;
  logic        sw_wr;
  logic        any_trip;

  // Pin, comparator, clock-loss one-shot and supply monitor are asynchronous,
  // so each passes two flops; the second stage idles at the inactive level.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= `RCSR_SYNC_INIT;
      sync2_q <= `RCSR_SYNC_INIT;
    end else begin
      sync1_q <= {vdd_low, clk_loss_timeout, cmp_out_n, rst_pin_n};
      sync2_q <= sync1_q;
    end
  end

  // Source qualification; disabled sources cannot reset the system.
  always_comb begin
    pin_low  = !sync2_q[0];
    cmp_trip = en_q.cmp_en && !sync2_q[1];
    loss_trip = en_q.loss_en && sync2_q[2];
    vdd_trip = en_q.vdd_en && sync2_q[3];
    hit      = (sfr.addr == `RCSR_SFR_ADDR);
    sw_wr    = sfr.wr && hit && sfr.wdata[`RCSR_BIT_SW];
    any_trip = pin_low || vdd_trip || loss_trip || wdt_timeout || flash_fault
               || cmp_trip || sw_wr;
  end

  // Sequencer next state. Only the internal reset is asserted; there is no
  // path back to the external pin at all, so it keeps its level. Enables are
  // kept across system resets so a detector stays armed after firing.
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    flags_d = flags_q;
    en_d    = en_q;
    rst_d   = rst_q;
    case (state_q)
      ST_RUN: begin
        if (any_trip) begin
          state_d = ST_HOLD;
          cnt_d   = HOLD_LOAD;
          rst_d   = 1'b0;
          flags_d = '0;
          if (pin_low) begin
            flags_d.pin_reset_flag = 1'b1;
          end else if (vdd_trip) begin
            flags_d.power_on_flag = 1'b1;
          end else if (loss_trip) begin
            flags_d.clock_loss_flag = 1'b1;
          end else if (wdt_timeout) begin
            flags_d.watchdog_flag = 1'b1;
          end else if (flash_fault) begin
            flags_d.flash_fault_flag = 1'b1;
          end else if (cmp_trip) begin
            flags_d.comparator_reset_flag = 1'b1;
          end else begin
            flags_d.soft_reset_flag = 1'b1;
          end
        end else if (sfr.wr && hit) begin
          en_d.vdd_en = sfr.wdata[`RCSR_BIT_POR];
          en_d.loss_en = sfr.wdata[`RCSR_BIT_LOSS];
          en_d.cmp_en = sfr.wdata[`RCSR_BIT_CMP];
        end
      end
      ST_HOLD: begin
        if (pin_low) begin
          cnt_d   = HOLD_LOAD;
          flags_d = '0;
          flags_d.pin_reset_flag = 1'b1;
        end else if (cnt_q == 8'h00) begin
          state_d = ST_RUN;
          rst_d   = 1'b1;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      default: begin
        state_d = ST_RUN;
        rst_d   = 1'b1;
      end
    endcase
  end

  // Read data answers one cycle after the strobe; unused bit 7 reads one.
  always_comb begin
    rdata_d = `RCSR_RDATA_IDLE;
    if (sfr.rd && hit) begin
      rdata_d = {`RCSR_BIT7_VALUE, flags_q};
    end
  end

  // Only the power-on reset clears this state; system resets do not.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_RUN;
      cnt_q   <= 8'h00;
      flags_q <= `RCSR_FLAGS_POR;
      en_q    <= `RCSR_EN_RESET;
      rst_q   <= 1'b1;
      rdata_q <= `RCSR_RDATA_IDLE;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      flags_q <= flags_d;
      en_q    <= en_d;
      rst_q   <= rst_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs straight from flops.
  assign sfr_rdata         = rdata_q;
  assign sys_rst_n         = rst_q;
  assign clock_loss_en     = en_q.loss_en;
  assign comparator_rst_en = en_q.cmp_en;
  assign vdd_rst_en        = en_q.vdd_en;

  // Checks of the sequencer. The soft-reset flag check needs every other source
  // quiet, because the priority order would hide the soft-reset flag.
  logic others_sw;
  assign others_sw = pin_low || vdd_trip || loss_trip || wdt_timeout || flash_fault
                     || cmp_trip;

  property p_sw_reset;
    @(posedge clk_sys) disable iff (!rst_n)
    (state_q == ST_RUN && sw_wr) |=> !sys_rst_n ##1 !sys_rst_n;
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("soft write gave no reset");

  property p_sw_flag;
    @(posedge clk_sys) disable iff (!rst_n)
    (state_q == ST_RUN && sw_wr && !others_sw) |=> flags_q == 7'h10;
  endproperty
  a_sw_flag: assert property (p_sw_flag) else $error("soft flag not alone");

  property p_no_pin_flag;
    @(posedge clk_sys) disable iff (!rst_n)
    $fell(sys_rst_n) && !$past(pin_low) |-> !flags_q.pin_reset_flag;
  endproperty
  a_no_pin_flag: assert property (p_no_pin_flag) else $error("pin flagged wrongly");

  property p_read;
    @(posedge clk_sys) disable iff (!rst_n)
    (sfr.rd && hit) |=> sfr_rdata == {1'b1, $past(flags_q)};
  endproperty
  a_read: assert property (p_read) else $error("register read mismatch");

  property p_pin;
    @(posedge clk_sys) disable iff (!rst_n)
    (state_q == ST_RUN && pin_low) |=> !sys_rst_n && flags_q == 7'h01;
  endproperty
  a_pin: assert property (p_pin) else $error("pin reset not flagged");

  property p_loss_en;
    @(posedge clk_sys) disable iff (!rst_n)
    (state_q == ST_RUN && !any_trip && sfr.wr && hit)
      |=> clock_loss_en == $past(sfr.wdata[2]) && comparator_rst_en == $past(sfr.wdata[5]);
  endproperty
  a_loss_en: assert property (p_loss_en) else $error("enable write lost");

  property p_cmp_off;
    @(posedge clk_sys) disable iff (!rst_n)
    (state_q == ST_RUN && !comparator_rst_en && !sync2_q[1] && !pin_low && !vdd_trip
     && !loss_trip && !wdt_timeout && !flash_fault && !sw_wr) |=> sys_rst_n;
  endproperty
  a_cmp_off: assert property (p_cmp_off) else $error("disabled comparator reset");

  property p_flash;
    @(posedge clk_sys) disable iff (!rst_n)
    (state_q == ST_RUN && flash_fault && !pin_low && !vdd_trip && !loss_trip && !wdt_timeout)
      |=> flags_q == 7'h40;
  endproperty
  a_flash: assert property (p_flash) else $error("flash fault not flagged");

  property p_onehot;
    @(posedge clk_sys) disable iff (!rst_n)
    $fell(sys_rst_n) |-> $onehot(flags_q) && $stable(en_q);
  endproperty
  a_onehot: assert property (p_onehot) else $error("cause flags not one-hot");

  property p_release;
    @(posedge clk_sys) disable iff (!rst_n)
    (state_q == ST_HOLD && cnt_q == 8'h00 && !pin_low) |=> sys_rst_n;
  endproperty
  a_release: assert property (p_release) else $error("system reset not released");

  // Main scenarios: software, pin and clock-loss resets, and the release.
  c_sw:    cover property (@(posedge clk_sys) disable iff (!rst_n)
                           $fell(sys_rst_n) && flags_q.soft_reset_flag);
  c_pin:   cover property (@(posedge clk_sys) disable iff (!rst_n)
                           $fell(sys_rst_n) && flags_q.pin_reset_flag);
  c_loss:  cover property (@(posedge clk_sys) disable iff (!rst_n)
                           $fell(sys_rst_n) && flags_q.clock_loss_flag);
  c_rel:   cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(sys_rst_n));

endmodule

// *** tb/test_reset_cause_and_soft_reset.sv ***
// Self-checking bench for the reset-cause register and its internal reset sequencer.
// Assumes rcsr_pkg and rcsr_top are compiled first and the header is on the include path.
`timescale 1ns/1ps
module test_reset_cause_and_soft_reset;
  import rcsr_pkg::*;

  localparam int HOLD = 2;

  logic          clk_sys   = 1'b0;
  logic          rst_n     = 1'b0;
  logic [6:0]    trip      = 7'h00;
  rcsr_sfr_req_t sfr       = '0;
  logic [7:0]    sfr_rdata;
  logic          sys_rst_n;
  logic          clock_loss_en;
  logic          comparator_rst_en;
  logic          vdd_rst_en;
  int            failures  = 0;
  int            cmp_count = 0;
  int            cyc       = 0;

  // Trip vector bit k drives the source whose flag sits in register bit k; bit 4 (soft reset) drives nothing.
  rcsr_top #(.HOLD_CYCLES(HOLD)) u_rcsr_top (
    .clk_sys          (clk_sys),
    .rst_n            (rst_n),
    .rst_pin_n        (~trip[0]),
    .cmp_out_n        (~trip[5]),
    .clk_loss_timeout (trip[2]),
    .vdd_low          (trip[1]),
    .wdt_timeout      (trip[3]),
    .flash_fault      (trip[6]),
    .sfr              (sfr),
    .sfr_rdata        (sfr_rdata),
    .sys_rst_n        (sys_rst_n),
    .clock_loss_en    (clock_loss_en),
    .comparator_rst_en(comparator_rst_en),
    .vdd_rst_en       (vdd_rst_en)
  );

  // Half period of 4 ns gives the 125 MHz system clock.
  always #4 clk_sys = ~clk_sys;

  // Cuts a hang short; the whole run needs well under a thousand cycles.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Enables placed at the bit positions where software writes them.
  function automatic logic [7:0] en_vec();
    return {2'b00, comparator_rst_en, 2'b00, clock_loss_en, vdd_rst_en, 1'b0};
  endfunction

  // Read data is valid for the one cycle after the strobe edge.
  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    @(negedge clk_sys);
    sfr.addr = addr;
    sfr.rd   = 1'b1;
    @(negedge clk_sys);
    sfr.rd = 1'b0;
    check("read data", sfr_rdata, exp);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_sys);
    sfr.addr  = addr;
    sfr.wdata = data;
    sfr.wr    = 1'b1;
    @(negedge clk_sys);
    sfr.wr = 1'b0;
  endtask

  // Bounded wait for the internal reset to reach a level.
  task automatic wait_sys(input logic lvl);
    int n;
    n = 0;
    while (sys_rst_n !== lvl && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    check("system reset level", {7'h00, sys_rst_n}, {7'h00, lvl});
  endtask

  // Trips one source, lets the hold run out, then expects only its flag.
  task automatic src_reset(input int k);
    @(negedge clk_sys);
    trip[k] = 1'b1;
    wait_sys(1'b0);
    trip[k] = 1'b0;
    wait_sys(1'b1);
    rd_chk(8'hEF, 8'h80 | (8'h01 << k));
  endtask

  initial begin
    int n;
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    rd_chk(8'hEF, 8'h82);
    check("enables after power-on", en_vec(), 8'h02);
    rd_chk(8'hEE, 8'h00);
    wr(8'hEE, 8'h10);
    check("reset from wrong address", {7'h00, sys_rst_n}, 8'h01);
    wr(8'hEF, 8'h26);
    check("enables written", en_vec(), 8'h26);
    // Soft reset must last exactly the hold length and leave the enables alone.
    wr(8'hEF, 8'h36);
    n = 0;
    while (sys_rst_n === 1'b0 && n < 40) begin
      n++;
      @(negedge clk_sys);
    end
    check("soft reset length", 8'(n), 8'(HOLD));
    rd_chk(8'hEF, 8'h90);
    check("enables kept", en_vec(), 8'h26);
    src_reset(6);
    src_reset(3);
    src_reset(2);
    src_reset(5);
    src_reset(0);
    src_reset(1);
    // With every enable cleared the gated sources must not reset.
    wr(8'hEF, 8'h00);
    check("enables cleared", en_vec(), 8'h00);
    trip = 7'h26;
    repeat (8) begin
      @(negedge clk_sys);
      check("gated sources", {7'h00, sys_rst_n}, 8'h01);
    end
    trip = 7'h00;
    repeat (3) @(negedge clk_sys);
    rd_chk(8'hEF, 8'h82);
    // A second power-on reset restores the defaults.
    wr(8'hEF, 8'h24);
    check("enables before second power-on", en_vec(), 8'h24);
    rst_n = 1'b0;
    @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    check("enables after second power-on", en_vec(), 8'h02);
    rd_chk(8'hEF, 8'h82);
    report_and_stop();
  end
endmodule
